// ===== rtl/dual_port_io.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - port h direction bit one tristates its pin as an input.
// - port h direction bit zero drives the pin from its latch bit.
// - port h latch register reads back latch contents, not pin levels.
// - port h upper nibble is analog 12..15 or digital, chosen by analog config.
// - port h lower nibble carries bus address 16..19 unless bus disabled.
// - after reset upper nibble is analog and reads as zero.
// - after reset lower nibble belongs to the bus address function.
// - port h pins and latch not reset; direction resets to all ones.
// - port j direction one tristates pin, zero drives pin from latch.
// - port j latch register is addressable and reads back the latch.
// - port j bits other than bit 5 are general i/o only while the memory bus is disabled.
// - in bus mode port j bits carry the memory control strobes.
// - port j bit 5 is never taken over by the bus.
// - an active peripheral may force a pin to output or input.
// - peripheral overrides never enter the direction register.
// - port j direction resets to all ones; pins and latch not reset.
// - pin register read gives pin levels, write updates the latch.
module dual_port_io
(
    input  wire logic       CLK_IN,
    input  wire logic       SRST_IN,
    input  wire logic [3:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output logic      [7:0] RDATA_OUT,
    input  wire logic [3:0] BUS_ADDR_HI_IN,
    input  wire logic [7:0] BUS_CTRL_IN,
    input  wire logic [7:0] PH_OVR_EN_IN,
    input  wire logic [7:0] PH_OVR_OUT_IN,
    input  wire logic [7:0] PH_OVR_DATA_IN,
    input  wire logic [7:0] PJ_OVR_EN_IN,
    input  wire logic [7:0] PJ_OVR_OUT_IN,
    input  wire logic [7:0] PJ_OVR_DATA_IN,
    input  wire logic [7:0] PH_PIN_IN,
    output logic      [7:0] PH_PIN_OUT,
    output logic      [7:0] PH_PIN_OE_OUT,
    input  wire logic [7:0] PJ_PIN_IN,
    output logic      [7:0] PJ_PIN_OUT,
    output logic      [7:0] PJ_PIN_OE_OUT,
    output logic      [3:0] ANALOG_SEL_OUT,
    output logic            BUS_ACTIVE_OUT
);
    import dual_io_pkg::*;

    logic [7:0] h_dir_r;
    logic [7:0] h_latch_r;
    logic [7:0] j_dir_r;
    logic [7:0] j_latch_r;
    logic [7:0] ana_cfg_r;
    logic [7:0] bus_cfg_r;
    logic [7:0] h_s1_r;
    logic [7:0] h_s2_r;
    logic [7:0] j_s1_r;
    logic [7:0] j_s2_r;
    logic [3:0] h_ana;
    logic       bus_on;
    logic [7:0] h_plain;
    logic [7:0] j_plain;
    logic [7:0] h_ovr;
    logic [7:0] j_ovr;
    logic [7:0] h_oe_nxt;
    logic [7:0] h_out_nxt;
    logic [7:0] j_oe_nxt;
    logic [7:0] j_out_nxt;
    logic [7:0] rdata_nxt;
    logic       wr_h_dir;
    logic       wr_j_dir;
    logic       wr_h_lat;
    logic       wr_j_lat;

    assign bus_on   = ~bus_cfg_r[BUS_DISABLE_BIT];
    assign wr_h_dir = WR_IN && (ADDR_IN == ADDR_H_DIR);
    assign wr_j_dir = WR_IN && (ADDR_IN == ADDR_J_DIR);
    // pins and latch registers both land in the latch
    assign wr_h_lat = WR_IN && (ADDR_IN == ADDR_H_PINS ||
                                ADDR_IN == ADDR_H_LATCH);
    assign wr_j_lat = WR_IN && (ADDR_IN == ADDR_J_PINS ||
                                ADDR_IN == ADDR_J_LATCH);

    // direction registers: only software writes reach them
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            h_dir_r <= DIR_RST;
            j_dir_r <= DIR_RST;
        end
        else
        begin
            if (wr_h_dir)
                h_dir_r <= WDATA_IN;
            if (wr_j_dir)
                j_dir_r <= WDATA_IN;
        end
    end

    // latches keep their value over reset, unknown at power-up
    always_ff @(posedge CLK_IN)
    begin
        if (wr_h_lat)
            h_latch_r <= WDATA_IN;
        if (wr_j_lat)
            j_latch_r <= WDATA_IN;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            ana_cfg_r <= ANA_CFG_RST;
            bus_cfg_r <= BUS_CFG_RST;
        end
        else
        begin
            if (WR_IN && ADDR_IN == ADDR_ANA_CFG)
                ana_cfg_r <= WDATA_IN & ANA_CFG_MASK;
            if (WR_IN && ADDR_IN == ADDR_BUS_CFG)
                bus_cfg_r <= WDATA_IN & BUS_CFG_MASK;
        end
    end

    // pins come from outside the clock domain
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            h_s1_r <= ZERO8;
            h_s2_r <= ZERO8;
            j_s1_r <= ZERO8;
            j_s2_r <= ZERO8;
        end
        else
        begin
            h_s1_r <= PH_PIN_IN;
            h_s2_r <= h_s1_r;
            j_s1_r <= PJ_PIN_IN;
            j_s2_r <= j_s1_r;
        end
    end

    // channel k is analog while the pin config field is at most 3-k
    for (genvar k = 0; k < 4; k++)
    begin : g_ana
        localparam logic [3:0] THR = 4'(AN_TOP - AN_BASE - k);
        assign h_ana[k] =
            ana_cfg_r[PIN_CFG_MSB:PIN_CFG_LSB] <= THR;
    end

    // per-bit pin ownership: bus, analog, peripheral, then software
    for (genvar i = 0; i < 8; i++)
    begin : g_bit
        logic h_bus;
        logic h_an;
        logic j_bus;
        assign h_bus = (i < H_SPLIT) && bus_on;
        assign h_an  = (i >= H_SPLIT) && h_ana[i % H_SPLIT];
        assign j_bus = (i != J_FREE_BIT) && bus_on;
        assign h_plain[i] = !h_bus && !h_an && !PH_OVR_EN_IN[i];
        assign j_plain[i] = !j_bus && !PJ_OVR_EN_IN[i];
        assign h_ovr[i]   = !h_bus && !h_an && PH_OVR_EN_IN[i];
        assign j_ovr[i]   = !j_bus && PJ_OVR_EN_IN[i];

        always_comb
        begin
            if (h_bus)
            begin
                h_oe_nxt[i]  = 1'b1;
                h_out_nxt[i] = BUS_ADDR_HI_IN[i % H_SPLIT];
            end
            else if (h_an)
            begin
                h_oe_nxt[i]  = 1'b0;
                h_out_nxt[i] = 1'b0;
            end
            else if (PH_OVR_EN_IN[i])
            begin
                h_oe_nxt[i]  = PH_OVR_OUT_IN[i];
                h_out_nxt[i] = PH_OVR_DATA_IN[i];
            end
            else
            begin
                h_oe_nxt[i]  = ~h_dir_r[i];
                h_out_nxt[i] = h_latch_r[i];
            end
        end

        always_comb
        begin
            if (j_bus)
            begin
                j_oe_nxt[i]  = 1'b1;
                j_out_nxt[i] = BUS_CTRL_IN[i];
            end
            else if (PJ_OVR_EN_IN[i])
            begin
                j_oe_nxt[i]  = PJ_OVR_OUT_IN[i];
                j_out_nxt[i] = PJ_OVR_DATA_IN[i];
            end
            else
            begin
                j_oe_nxt[i]  = ~j_dir_r[i];
                j_out_nxt[i] = j_latch_r[i];
            end
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            PH_PIN_OE_OUT  <= ZERO8;
            PH_PIN_OUT     <= ZERO8;
            PJ_PIN_OE_OUT  <= ZERO8;
            PJ_PIN_OUT     <= ZERO8;
            ANALOG_SEL_OUT <= ANA_SEL_RST;
            BUS_ACTIVE_OUT <= 1'b0;
        end
        else
        begin
            PH_PIN_OE_OUT  <= h_oe_nxt;
            PH_PIN_OUT     <= h_out_nxt;
            PJ_PIN_OE_OUT  <= j_oe_nxt;
            PJ_PIN_OUT     <= j_out_nxt;
            ANALOG_SEL_OUT <= h_ana;
            BUS_ACTIVE_OUT <= bus_on;
        end
    end

    always_comb
    begin
        unique case (ADDR_IN)
            // analog pins read zero in the digital path
            ADDR_H_PINS:  rdata_nxt = h_s2_r & ~{h_ana, 4'h0};
            ADDR_H_LATCH: rdata_nxt = h_latch_r;
            ADDR_H_DIR:   rdata_nxt = h_dir_r;
            ADDR_J_PINS:  rdata_nxt = j_s2_r;
            ADDR_J_LATCH: rdata_nxt = j_latch_r;
            ADDR_J_DIR:   rdata_nxt = j_dir_r;
            ADDR_ANA_CFG: rdata_nxt = ana_cfg_r;
            ADDR_BUS_CFG: rdata_nxt = bus_cfg_r;
            default:      rdata_nxt = ZERO8;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            RDATA_OUT <= ZERO8;
        else if (RD_IN)
            RDATA_OUT <= rdata_nxt;
        else
            RDATA_OUT <= ZERO8;
    end

    h_input_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        (($past(h_plain & h_dir_r) & PH_PIN_OE_OUT) == 8'h00))
        else $error("port h input pin is driven");

    h_drive_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !$past(SRST_IN) |->
        (($past(h_plain & ~h_dir_r) & ~PH_PIN_OE_OUT) == 8'h00) &&
        (($past(h_plain & ~h_dir_r) & (PH_PIN_OUT ^ $past(h_latch_r)))
            == 8'h00))
        else $error("port h output pin not driven from latch");

    h_override_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !$past(SRST_IN) |->
        ((PH_PIN_OE_OUT ^ $past(PH_OVR_OUT_IN)) & $past(h_ovr)) == 8'h00 &&
        ((PH_PIN_OUT ^ $past(PH_OVR_DATA_IN)) & $past(h_ovr)) == 8'h00)
        else $error("port h peripheral override ignored");

    analog_off_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        (PH_PIN_OE_OUT[7:4] & $past(h_ana)) == 4'h0)
        else $error("analog pin is driven");

    latch_read_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        RD_IN && ADDR_IN == ADDR_H_LATCH |=>
        RDATA_OUT == $past(h_latch_r))
        else $error("latch read did not return latch");

    j_latch_read_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        RD_IN && ADDR_IN == ADDR_J_LATCH |=>
        RDATA_OUT == $past(j_latch_r))
        else $error("port j latch read did not return latch");

    analog_zero_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        RD_IN && ADDR_IN == ADDR_H_PINS |=>
        (RDATA_OUT[7:4] & $past(h_ana)) == 4'h0)
        else $error("analog pin read not zero");

    rdata_idle_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !RD_IN |=> RDATA_OUT == ZERO8)
        else $error("read data outside its cycle");

    bus_addr_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !$past(SRST_IN) && $past(bus_on) |->
        PH_PIN_OE_OUT[3:0] == 4'hF &&
        PH_PIN_OUT[3:0] == $past(BUS_ADDR_HI_IN))
        else $error("bus address not on port h low nibble");

    reset_mode_a: assert property (
        @(posedge CLK_IN)
        SRST_IN |=> bus_on && h_ana == ANA_SEL_RST &&
        h_dir_r == DIR_RST && j_dir_r == DIR_RST)
        else $error("reset state wrong");

    j_input_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        (($past(j_plain & j_dir_r) & PJ_PIN_OE_OUT) == 8'h00))
        else $error("port j input pin is driven");

    j_drive_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !$past(SRST_IN) |->
        (($past(j_plain & ~j_dir_r) & ~PJ_PIN_OE_OUT) == 8'h00) &&
        (($past(j_plain & ~j_dir_r) & (PJ_PIN_OUT ^ $past(j_latch_r)))
            == 8'h00))
        else $error("port j output pin not driven from latch");

    j_bus_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !$past(SRST_IN) && $past(bus_on) |->
        PJ_PIN_OE_OUT[7:6] == 2'h3 && PJ_PIN_OE_OUT[4:0] == 5'h1F &&
        PJ_PIN_OUT[7:6] == $past(BUS_CTRL_IN[7:6]) &&
        PJ_PIN_OUT[4:0] == $past(BUS_CTRL_IN[4:0]))
        else $error("port j bus strobes not driven");

    j_free_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !$past(SRST_IN) && $past(bus_on && !PJ_OVR_EN_IN[5]) |->
        PJ_PIN_OE_OUT[5] == !$past(j_dir_r[5]))
        else $error("port j bit 5 taken by bus");

    j_override_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !$past(SRST_IN) |->
        ((PJ_PIN_OE_OUT ^ $past(PJ_OVR_OUT_IN)) & $past(j_ovr)) == 8'h00 &&
        ((PJ_PIN_OUT ^ $past(PJ_OVR_DATA_IN)) & $past(j_ovr)) == 8'h00)
        else $error("port j peripheral override ignored");

    dir_hold_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        !wr_h_dir && !wr_j_dir |=>
        $stable(h_dir_r) && $stable(j_dir_r))
        else $error("direction changed without write");

    pin_write_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        WR_IN && ADDR_IN == ADDR_J_PINS |=>
        j_latch_r == $past(WDATA_IN))
        else $error("pin write missed latch");

    h_pin_write_a: assert property (
        @(posedge CLK_IN) disable iff (SRST_IN)
        WR_IN && ADDR_IN == ADDR_H_PINS |=>
        h_latch_r == $past(WDATA_IN))
        else $error("port h pin write missed latch");

    bus_off_c: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        WR_IN && ADDR_IN == ADDR_BUS_CFG && WDATA_IN[BUS_DISABLE_BIT]);
    digital_c: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        h_ana == 4'h0 ##1 RD_IN && ADDR_IN == ADDR_H_PINS);
    override_c: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        PH_OVR_EN_IN != 8'h00 && !bus_on);
    bus_addr_c: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        bus_on && BUS_ADDR_HI_IN != 4'h0);
    j_override_c: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        PJ_OVR_EN_IN != 8'h00 && !bus_on);
endmodule : dual_port_io

// ===== rtl/dual_io_pkg.sv
package dual_io_pkg;
    // register index on the plain software port
    localparam logic [3:0] ADDR_H_PINS   = 4'h0;
    localparam logic [3:0] ADDR_H_LATCH  = 4'h1;
    localparam logic [3:0] ADDR_H_DIR    = 4'h2;
    localparam logic [3:0] ADDR_J_PINS   = 4'h3;
    localparam logic [3:0] ADDR_J_LATCH  = 4'h4;
    localparam logic [3:0] ADDR_J_DIR    = 4'h5;
    localparam logic [3:0] ADDR_ANA_CFG  = 4'h6;
    localparam logic [3:0] ADDR_BUS_CFG  = 4'h7;

    // reset values
    localparam logic [7:0] DIR_RST       = 8'hFF;
    localparam logic [7:0] ANA_CFG_RST   = 8'h00;
    localparam logic [7:0] BUS_CFG_RST   = 8'h00;
    localparam logic [7:0] ZERO8         = 8'h00;
    localparam logic [3:0] ANA_SEL_RST   = 4'hF;

    // implemented bits; the rest read as zero
    localparam logic [7:0] ANA_CFG_MASK  = 8'h3F;
    localparam logic [7:0] BUS_CFG_MASK  = 8'hB3;

    // field positions
    localparam int PIN_CFG_LSB           = 0;
    localparam int PIN_CFG_MSB           = 3;
    localparam int BUS_DISABLE_BIT       = 7;

    // analog channels on the upper half of port h
    localparam int AN_BASE               = 12;
    localparam int AN_TOP                = 15;
    localparam int H_SPLIT               = 4;

    // port j bit that the memory bus never takes
    localparam int J_FREE_BIT            = 5;
endpackage : dual_io_pkg

// ===== bench/ext_mem_model.sv
`timescale 1ns/1ps
// far side: memory devices and loads on both ports
// a pin the block releases shows the level the far side puts on it
module ext_mem_model
(
    input  wire logic [7:0] h_out_in,
    input  wire logic [7:0] h_oe_in,
    input  wire logic [7:0] j_out_in,
    input  wire logic [7:0] j_oe_in,
    input  wire logic [7:0] h_ext_in,
    input  wire logic [7:0] j_ext_in,
    output logic      [7:0] h_lvl_out,
    output logic      [7:0] j_lvl_out
);
    // no pulls on these lines, so the bench moves ext off old values
    assign h_lvl_out = (h_oe_in & h_out_in) | (~h_oe_in & h_ext_in);
    assign j_lvl_out = (j_oe_in & j_out_in) | (~j_oe_in & j_ext_in);
endmodule : ext_mem_model

// ===== bench/dual_port_io_with_bus_mux_tb.sv
`timescale 1ns/1ps
module dual_port_io_with_bus_mux_tb;
    import dual_io_pkg::*;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [3:0] bus_a = 4'hB;
    logic [3:0] ana_sel;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       bus_act;
    logic [7:0] rdata, ctrl = 8'h86, e;
    logic [7:0] ph_en = 8'h00, ph_ov = 8'h00, ph_dat = 8'h00;
    logic [7:0] pj_en = 8'h00, pj_ov = 8'h00, pj_dat = 8'h00;
    logic [7:0] ph_in, ph_out, ph_oe, pj_in, pj_out, pj_oe;
    logic [7:0] h_ext = 8'hFF, j_ext = 8'h5A;
    int         err_total = 0;
    int         checks_done = 0;

    always #5 clk = ~clk;

    dual_port_io dut_u (.CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .BUS_ADDR_HI_IN(bus_a), .BUS_CTRL_IN(ctrl), .PH_OVR_EN_IN(ph_en),
        .PH_OVR_OUT_IN(ph_ov), .PH_OVR_DATA_IN(ph_dat),
        .PJ_OVR_EN_IN(pj_en), .PJ_OVR_OUT_IN(pj_ov),
        .PJ_OVR_DATA_IN(pj_dat), .PH_PIN_IN(ph_in), .PH_PIN_OUT(ph_out),
        .PH_PIN_OE_OUT(ph_oe), .PJ_PIN_IN(pj_in), .PJ_PIN_OUT(pj_out),
        .PJ_PIN_OE_OUT(pj_oe), .ANALOG_SEL_OUT(ana_sel),
        .BUS_ACTIVE_OUT(bus_act));

    ext_mem_model far_u (.h_out_in(ph_out), .h_oe_in(ph_oe),
        .j_out_in(pj_out), .j_oe_in(pj_oe), .h_ext_in(h_ext),
        .j_ext_in(j_ext), .h_lvl_out(ph_in), .j_lvl_out(pj_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    // outputs lag one cycle, pin reads two more for the synchroniser
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic tally_and_finish;
        $display("mismatches %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic t_reset_state;
        chk({7'h00, bus_act}, 8'h01);
        chk({4'h0, ana_sel}, 8'h0F);
        chk(ph_oe, 8'h0F);
        chk(ph_out & 8'h0F, {4'h0, bus_a});
        rd_chk(ADDR_H_PINS, {4'h0, bus_a});
        rd_chk(ADDR_H_DIR, 8'hFF);
        rd_chk(ADDR_J_DIR, 8'hFF);
        rd_chk(ADDR_ANA_CFG, 8'h00);
        rd_chk(ADDR_BUS_CFG, 8'h00);
        chk(pj_oe, 8'hDF);
    endtask : t_reset_state

    task automatic t_port_h;
        wr_reg(ADDR_BUS_CFG, 8'h80);
        wr_reg(ADDR_ANA_CFG, 8'h0F);
        wr_reg(ADDR_H_LATCH, 8'hA5);
        wr_reg(ADDR_H_DIR, 8'h00);
        h_ext <= 8'h3C;
        settle();
        chk({7'h00, bus_act}, 8'h00);
        chk(ph_oe, 8'hFF);
        chk(ph_out, 8'hA5);
        wr_reg(ADDR_H_DIR, 8'hF0);
        settle();
        chk(ph_oe, 8'h0F);
        rd_chk(ADDR_H_PINS, 8'h35);
        rd_chk(ADDR_H_LATCH, 8'hA5);
        wr_reg(ADDR_H_PINS, 8'h5A);
        rd_chk(ADDR_H_LATCH, 8'h5A);
        @(posedge clk);
        #1;
        chk(rdata, 8'h00);
    endtask : t_port_h

    task automatic t_port_j;
        wr_reg(ADDR_BUS_CFG, 8'h00);
        wr_reg(ADDR_J_LATCH, 8'h3C);
        wr_reg(ADDR_J_DIR, 8'h00);
        wr_reg(ADDR_H_DIR, 8'h00);
        bus_a <= 4'h4;
        settle();
        chk({7'h00, bus_act}, 8'h01);
        chk(pj_out, 8'hA6);
        chk(ph_out & 8'h0F, {4'h0, bus_a});
        rd_chk(ADDR_J_DIR, 8'h00);
        rd_chk(ADDR_J_LATCH, 8'h3C);
        wr_reg(ADDR_BUS_CFG, 8'h80);
        wr_reg(ADDR_J_DIR, 8'h0F);
        settle();
        chk(pj_oe, 8'hF0);
        chk(pj_out & 8'hF0, 8'h30);
        rd_chk(ADDR_J_PINS, 8'h3A);
        wr_reg(ADDR_J_PINS, 8'hC5);
        rd_chk(ADDR_J_LATCH, 8'hC5);
    endtask : t_port_j

    task automatic t_override;
        wr_reg(ADDR_J_DIR, 8'hFD);
        wr_reg(ADDR_H_DIR, 8'hFF);
        pj_en <= 8'h03;
        pj_ov <= 8'h01;
        pj_dat <= 8'h01;
        ph_en <= 8'h80;
        ph_ov <= 8'h80;
        ph_dat <= 8'h80;
        settle();
        chk(pj_oe, 8'h01);
        chk(pj_out & 8'h01, 8'h01);
        chk(ph_oe, 8'h80);
        chk(ph_out & 8'h80, 8'h80);
        rd_chk(ADDR_J_DIR, 8'hFD);
        rd_chk(ADDR_H_DIR, 8'hFF);
    endtask : t_override

    // field f makes channel 12+k analog while f + k stays within 3
    task automatic t_analog;
        for (int f = 0; f < 5; f++)
        begin
            wr_reg(ADDR_ANA_CFG, 8'(f));
            settle();
            e = 8'h00;
            for (int k = 0; k < 4; k++)
                e[k] = (f + k <= 3);
            chk({4'h0, ana_sel}, e);
        end
        wr_reg(ADDR_ANA_CFG, 8'hFF);
        rd_chk(ADDR_ANA_CFG, 8'h3F);
        wr_reg(ADDR_BUS_CFG, 8'hFF);
        rd_chk(ADDR_BUS_CFG, 8'hB3);
        wr_reg(4'h8, 8'hFF);
        rd_chk(4'h8, 8'h00);
    endtask : t_analog

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        settle();
        t_reset_state();
        t_port_h();
        t_port_j();
        t_override();
        t_analog();
        tally_and_finish();
    end
endmodule : dual_port_io_with_bus_mux_tb
